// *** design/mpp_consts.svh ***
// register indices, field positions, reset values and counts of the multipurpose pin block
`ifndef MPP_CONSTS_SVH
`define MPP_CONSTS_SVH
`define MPP_NUM_PINS        14
`define MPP_IDX_MODE_BASE   16'hF510
`define MPP_IDX_SWIN        16'hF530
`define MPP_IDX_GPIN        16'hF531
`define MPP_IDX_LINK        16'hF532
`define MPP_IDX_MIC0        16'hF560
`define MPP_IDX_MIC1        16'hF561
`define MPP_MODE_LSB        0
`define MPP_MODE_DEB_BIT    3
`define MPP_MIC_SEL_LSB     0
`define MPP_MIC_EN_BIT      4
`define MPP_RST_MODE        4'h0
`define MPP_RST_MIC         16'h0000
`define MPP_RST_SWIN        14'h0000
`define MPP_FRAME_BITS      64
`define MPP_DEB_CYCLES      16
`define MPP_RESP_OKAY       2'h0
`define MPP_RESP_SLVERR     2'h2
`endif

// *** design/mpp_pkg.sv ***
// types of the multipurpose pin and microphone block
package mpp_pkg;
    typedef enum logic [2:0] {
        MPP_HW_IN   = 3'h0,
        MPP_SW_IN   = 3'h1,
        MPP_OUT_PU  = 3'h2,
        MPP_OUT_NP  = 3'h3,
        MPP_MIC_IN  = 3'h4,
        MPP_PANIC   = 3'h5,
        MPP_SPI_SS  = 3'h6,
        MPP_UNUSED  = 3'h7
    } mpp_mode_t;

    typedef struct packed {
        logic                aw_have;
        logic [15:0]         aw_idx;
        logic                w_have;
        logic [31:0]         wdata;
        logic [3:0]          wstrb;
        logic                awready;
        logic                wready;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                arready;
        logic                rvalid;
        logic [31:0]         rdata;
        logic [1:0]          rresp;
        logic [13:0][3:0]    pin_mode_setting;
        logic [13:0]         swin;
        logic [15:0]         mic_pair0_control;
        logic [15:0]         mic_pair1_control;
        logic                link_master;
        logic [13:0]         pin_s1;
        logic [13:0]         pin_s2;
        logic [13:0]         filt;
        logic [13:0][4:0]    deb_cnt;
        logic                tog_s1;
        logic                tog_s2;
        logic                tog_s3;
        logic [13:0]         gp_in;
        logic [13:0]         gp_in_valid;
        logic [13:0]         pin_o;
        logic [13:0]         pin_oe;
        logic [13:0]         pin_pu;
        logic [3:0][6:0]     mic_data;
        logic                mic_valid;
    } mpp_state_t;

    typedef struct packed {
        logic [9:0]          cfg_s1;
        logic [9:0]          cfg_s2;
        logic [27:0]         pin_r1;
        logic [27:0]         pin_r2;
        logic [6:0]          bitcnt;
        logic [3:0][6:0]     cnt;
        logic [3:0][6:0]     hold;
        logic                tog;
    } mpp_link_t;
endpackage

// *** design/mpp_top.sv ***
// multipurpose pins with pdm microphone inputs behind an axi4-lite slave
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "mpp_consts.svh"
module mpp_top
    import mpp_pkg::*;
#(
    parameter int FRAME_BITS = `MPP_FRAME_BITS,
    parameter int DEB_CYCLES = `MPP_DEB_CYCLES
)(
    input  wire logic              aclk,                // system clock
    input  wire logic              aresetn,             // active-low reset, synchronous in the aclk domain, asynchronous at the link reset flops
    input  wire logic              port_bit_clk,        // serial port bit clock
    input  wire logic [17:0]       awaddr,              // write address
    input  wire logic              awvalid,             // write address valid
    output logic                   awready,             // write address ready
    input  wire logic [31:0]       wdata,               // write data
    input  wire logic [3:0]        wstrb,               // write strobes
    input  wire logic              wvalid,              // write data valid
    output logic                   wready,              // write data ready
    output logic [1:0]             bresp,               // write response
    output logic                   bvalid,              // write response valid
    input  wire logic              bready,              // write response ready
    input  wire logic [17:0]       araddr,              // read address
    input  wire logic              arvalid,             // read address valid
    output logic                   arready,             // read address ready
    output logic [31:0]            rdata,               // read data
    output logic [1:0]             rresp,               // read response
    output logic                   rvalid,              // read data valid
    input  wire logic              rready,              // read data ready
    input  wire logic [13:0]       multipurpose_pin_i,  // pin levels
    output logic [13:0]            multipurpose_pin_o,  // pin drive value
    output logic [13:0]            multipurpose_pin_oe, // pin drive enable
    output logic [13:0]            multipurpose_pin_pu, // pin pull-up enable
    input  wire logic [13:0]       dsp_gp_out,          // program output values
    output logic [13:0]            dsp_gp_in,           // program input values
    output logic [13:0]            dsp_gp_in_valid,     // input value valid
    input  wire logic              panic_flag,          // panic manager flag
    input  wire logic              spi_ss_n,            // master spi select
    output logic                   bit_clk_master_oe,   // bit clock pad drives
    output logic [3:0][6:0]        mic_sample,          // decimated samples
    output logic                   mic_sample_valid     // one-cycle sample strobe
);
    mpp_state_t s;
    mpp_state_t n;
    mpp_link_t  l;
    mpp_link_t  ln;
    logic [13:0] fall_cap_reg;
    logic        lrst_s1_reg;
    logic        lrst_s2_reg;
    logic [13:0] in_mask;
    logic [13:0] gpo_mask;
    logic [13:0] oe_mask;
    logic        tick;
    // pin index of a mode register, or 15 when not one
    function automatic logic [3:0] mode_pin(input logic [15:0] idx);
        if (idx[15:4] == `MPP_IDX_MODE_BASE >> 4 && idx[3:0] < 4'(`MPP_NUM_PINS))
            return idx[3:0];
        return 4'hF;
    endfunction
    // byte-lane merge of a write into a register word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
            if (strb[b])
                r[8*b +: 8] = d[8*b +: 8];
        return r;
    endfunction
    // read mux over the register map
    function automatic logic [32:0] rd_word(input logic [15:0] idx, input mpp_state_t st);
        logic [3:0] p;
        p = mode_pin(idx);
        if (p != 4'hF)
            return {1'b1, 28'h0000000, st.pin_mode_setting[p]};
        case (idx)
            `MPP_IDX_SWIN: return {1'b1, 18'h00000, st.swin};
            `MPP_IDX_GPIN: return {1'b1, 18'h00000, st.gp_in};
            `MPP_IDX_LINK: return {1'b1, 31'h00000000, st.link_master};
            `MPP_IDX_MIC0: return {1'b1, 16'h0000, st.mic_pair0_control};
            `MPP_IDX_MIC1: return {1'b1, 16'h0000, st.mic_pair1_control};
            default:       return {1'b0, 32'h00000000};
        endcase
    endfunction
    // sample tick: frame toggle from the link domain after two flops
    assign tick = s.tog_s2 ^ s.tog_s3;
    // per-pin mode masks
    always_comb
    begin
        for (int i = 0; i < `MPP_NUM_PINS; i++)
        begin
            in_mask[i]  = s.pin_mode_setting[i][2:0] inside {MPP_HW_IN, MPP_SW_IN};
            gpo_mask[i] = s.pin_mode_setting[i][2:0] inside {MPP_OUT_PU, MPP_OUT_NP};
            oe_mask[i]  = gpo_mask[i] || s.pin_mode_setting[i][2:0] inside {MPP_PANIC, MPP_SPI_SS};
        end
    end
    // next state of the system domain
    always_comb
    begin
        logic [31:0] wv;
        logic [32:0] rv;
        logic [3:0]  p;
        mpp_mode_t   m;
        n = s;
        wv = 32'h00000000;
        rv = 33'h000000000;
        p = 4'hF;
        m = MPP_HW_IN;
        // write address and data taken in either order
        if (s.awready && awvalid)
        begin
            n.aw_have = 1'b1;
            n.aw_idx  = awaddr[17:2];
        end
        if (s.wready && wvalid)
        begin
            n.w_have = 1'b1;
            n.wdata  = wdata;
            n.wstrb  = wstrb;
        end
        if (s.bvalid && bready)
            n.bvalid = 1'b0;
        if (s.aw_have && s.w_have && !s.bvalid)
        begin
            n.aw_have = 1'b0;
            n.w_have  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = `MPP_RESP_OKAY;
            p = mode_pin(s.aw_idx);
            if (p != 4'hF)
            begin
                wv = merge({28'h0000000, s.pin_mode_setting[p]}, s.wdata, s.wstrb);
                n.pin_mode_setting[p] = wv[3:0];
            end
            else
            begin
                case (s.aw_idx)
                    `MPP_IDX_SWIN:
                    begin
                        wv = merge({18'h00000, s.swin}, s.wdata, s.wstrb);
                        n.swin = wv[13:0];
                    end
                    `MPP_IDX_LINK:
                    begin
                        wv = merge({31'h00000000, s.link_master}, s.wdata, s.wstrb);
                        n.link_master = wv[0];
                    end
                    `MPP_IDX_MIC0:
                    begin
                        wv = merge({16'h0000, s.mic_pair0_control}, s.wdata, s.wstrb);
                        n.mic_pair0_control = wv[15:0];
                    end
                    `MPP_IDX_MIC1:
                    begin
                        wv = merge({16'h0000, s.mic_pair1_control}, s.wdata, s.wstrb);
                        n.mic_pair1_control = wv[15:0];
                    end
                    default: n.bresp = `MPP_RESP_SLVERR;
                endcase
            end
        end
        n.awready = !n.aw_have && !n.bvalid;
        n.wready  = !n.w_have && !n.bvalid;
        // read channel, answer one cycle after the address
        if (s.rvalid && rready)
            n.rvalid = 1'b0;
        if (s.arready && arvalid)
        begin
            rv = rd_word(araddr[17:2], s);
            n.rvalid = 1'b1;
            n.rdata  = rv[31:0];
            n.rresp  = rv[32] ? `MPP_RESP_OKAY : `MPP_RESP_SLVERR;
        end
        n.arready = !n.rvalid;
        // pin synchronisers and sample tick
        n.pin_s1 = multipurpose_pin_i;
        n.pin_s2 = s.pin_s1;
        n.tog_s1 = l.tog;
        n.tog_s2 = s.tog_s1;
        n.tog_s3 = s.tog_s2;
        // per-pin debounce, input capture and output drive
        for (int i = 0; i < `MPP_NUM_PINS; i++)
        begin
            m = mpp_mode_t'(s.pin_mode_setting[i][2:0]);
            if (!s.pin_mode_setting[i][`MPP_MODE_DEB_BIT] || s.pin_s2[i] == s.filt[i])
            begin
                n.filt[i]    = s.pin_s2[i];
                n.deb_cnt[i] = 5'h00;
            end
            else if (s.deb_cnt[i] == 5'(DEB_CYCLES - 1))
            begin
                n.filt[i]    = s.pin_s2[i];
                n.deb_cnt[i] = 5'h00;
            end
            else
                n.deb_cnt[i] = s.deb_cnt[i] + 5'h01;
            n.gp_in_valid[i] = in_mask[i];
            if (tick)
            begin
                n.gp_in[i] = (m == MPP_SW_IN) ? s.swin[i] :
                             (m == MPP_HW_IN) ? s.filt[i] : 1'b0;
                if (gpo_mask[i])
                    n.pin_o[i] = dsp_gp_out[i];
            end
            if (!gpo_mask[i])
                n.pin_o[i] = (m == MPP_PANIC) ? panic_flag :
                             (m == MPP_SPI_SS) ? spi_ss_n : 1'b0;
            n.pin_oe[i] = oe_mask[i];
            n.pin_pu[i] = (m == MPP_OUT_PU);
        end
        // decimated samples held stable by the link side for a frame
        n.mic_valid = tick;
        if (tick)
            n.mic_data = l.hold;
        if (!aresetn)
        begin
            n = '0;
            n.awready = 1'b1;
            n.wready  = 1'b1;
            n.arready = 1'b1;
            n.bresp   = `MPP_RESP_OKAY;
            n.rresp   = `MPP_RESP_OKAY;
            for (int i = 0; i < `MPP_NUM_PINS; i++)
                n.pin_mode_setting[i] = `MPP_RST_MODE;
            n.swin = `MPP_RST_SWIN;
            n.mic_pair0_control = `MPP_RST_MIC;
            n.mic_pair1_control = `MPP_RST_MIC;
        end
    end
    // system domain registers
    always_ff @(posedge aclk)
    begin
        s <= n;
    end
    // link reset: set at once, released through two flops, so a short reset still clears it
    always_ff @(posedge port_bit_clk or negedge aresetn)
    begin
        if (!aresetn)
            {lrst_s2_reg, lrst_s1_reg} <= 2'b00;
        else
            {lrst_s2_reg, lrst_s1_reg} <= {lrst_s1_reg, 1'b1};
    end
    // falling-edge capture for the second microphone of each pair
    always_ff @(negedge port_bit_clk)
    begin
        fall_cap_reg <= multipurpose_pin_i;
    end
    // next state of the link domain: pdm count per channel over one frame
    always_comb
    begin
        logic [3:0] sel;
        logic       en;
        logic       bitv;
        logic       last;
        logic [6:0] sum;
        ln = l;
        sel = 4'h0;
        en = 1'b0;
        bitv = 1'b0;
        last = 1'b0;
        sum = 7'h00;
        ln.cfg_s1 = {s.mic_pair1_control[`MPP_MIC_EN_BIT:`MPP_MIC_SEL_LSB],
                     s.mic_pair0_control[`MPP_MIC_EN_BIT:`MPP_MIC_SEL_LSB]};
        ln.cfg_s2 = l.cfg_s1;
        ln.pin_r1 = {multipurpose_pin_i, fall_cap_reg};
        ln.pin_r2 = l.pin_r1;
        last = (l.bitcnt == 7'(FRAME_BITS - 1));
        ln.bitcnt = last ? 7'h00 : l.bitcnt + 7'h01;
        for (int c = 0; c < 4; c++)
        begin
            sel = l.cfg_s2[5*(c/2) +: 4];
            en  = l.cfg_s2[5*(c/2) + 4];
            if (sel < 4'(`MPP_NUM_PINS))
                bitv = (c % 2 == 0) ? l.pin_r2[14 + int'(sel)] : l.pin_r2[int'(sel)];
            else
                bitv = 1'b0;
            sum = l.cnt[c] + {6'h00, bitv & en};
            if (last)
            begin
                ln.hold[c] = sum;
                ln.cnt[c]  = 7'h00;
            end
            else
                ln.cnt[c] = sum;
        end
        if (last)
            ln.tog = ~l.tog;
        if (!lrst_s2_reg)
            ln = '0;
    end
    // link domain registers
    always_ff @(posedge port_bit_clk)
    begin
        l <= ln;
    end
    // outputs straight from flip-flops
    assign awready             = s.awready;
    assign wready              = s.wready;
    assign bvalid              = s.bvalid;
    assign bresp               = s.bresp;
    assign arready             = s.arready;
    assign rvalid              = s.rvalid;
    assign rdata               = s.rdata;
    assign rresp               = s.rresp;
    assign multipurpose_pin_o  = s.pin_o;
    assign multipurpose_pin_oe = s.pin_oe;
    assign multipurpose_pin_pu = s.pin_pu;
    assign dsp_gp_in           = s.gp_in;
    assign dsp_gp_in_valid     = s.gp_in_valid;
    assign bit_clk_master_oe   = s.link_master;
    assign mic_sample          = s.mic_data;
    assign mic_sample_valid    = s.mic_valid;
    // checks on pin drive, sampling and the register bus
    property p_oe_only_output;
        @(posedge aclk) disable iff (!aresetn)
        $past(aresetn) |-> (s.pin_oe & ~$past(oe_mask)) == 14'h0000;
    endproperty
    a_oe_only_output: assert property (p_oe_only_output)
        else $error("pin driven outside an output mode");
    property p_gpo_once_per_sample;
        @(posedge aclk) disable iff (!aresetn)
        !$past(tick) |-> ((s.pin_o ^ $past(s.pin_o)) & $past(gpo_mask)) == 14'h0000;
    endproperty
    a_gpo_once_per_sample: assert property (p_gpo_once_per_sample)
        else $error("gp output changed without a sample tick");
    property p_gpo_value;
        @(posedge aclk) disable iff (!aresetn)
        tick |=> ((s.pin_o ^ $past(dsp_gp_out)) & $past(gpo_mask)) == 14'h0000;
    endproperty
    a_gpo_value: assert property (p_gpo_value)
        else $error("gp output does not carry the program value");
    property p_in_valid;
        @(posedge aclk) disable iff (!aresetn)
        $past(aresetn) |-> s.gp_in_valid == $past(in_mask);
    endproperty
    a_in_valid: assert property (p_in_valid)
        else $error("input valid does not follow the pin mode");
    property p_swin;
        @(posedge aclk) disable iff (!aresetn)
        (tick && s.pin_mode_setting[0][2:0] == MPP_SW_IN) ##1 1'b1
            |-> s.gp_in[0] == $past(s.swin[0], 1);
    endproperty
    a_swin: assert property (p_swin)
        else $error("software input value not presented");
    property p_mic_pulse;
        @(posedge aclk) disable iff (!aresetn)
        mic_sample_valid |=> !mic_sample_valid [*2];
    endproperty
    a_mic_pulse: assert property (p_mic_pulse)
        else $error("sample strobe longer than one cycle");
    property p_mic0_write;
        @(posedge aclk) disable iff (!aresetn)
        (s.aw_have && s.w_have && !s.bvalid && s.aw_idx == `MPP_IDX_MIC0 && s.wstrb == 4'hF)
            |=> s.mic_pair0_control == $past(s.wdata[15:0]) && s.bvalid;
    endproperty
    a_mic0_write: assert property (p_mic0_write)
        else $error("mic pair 0 control not written");
    property p_bvalid_hold;
        @(posedge aclk) disable iff (!aresetn)
        bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    a_bvalid_hold: assert property (p_bvalid_hold)
        else $error("write response dropped before ready");
    property p_deb_hold;
        @(posedge aclk) disable iff (!aresetn)
        (s.pin_mode_setting[0][`MPP_MODE_DEB_BIT] && s.filt[0] != s.pin_s2[0]
            && s.deb_cnt[0] != 5'(DEB_CYCLES - 1)) |=> $stable(s.filt[0]);
    endproperty
    a_deb_hold: assert property (p_deb_hold)
        else $error("debounced input changed early");
    property p_pdm_count;
        @(posedge port_bit_clk) disable iff (!lrst_s2_reg)
        l.bitcnt == 7'h00 |-> l.cnt[0] == 7'h00 && l.cnt[3] == 7'h00;
    endproperty
    a_pdm_count: assert property (p_pdm_count)
        else $error("pdm count not cleared at frame start");
endmodule

// *** verif/mpp_mic_model.sv ***
// pdm microphone pairs sharing two data lines
`timescale 1ns/1ps
module mpp_mic_model (
    input  wire logic       bclk,  // microphone clock from the device
    input  wire logic [1:0] l_bit, // left mic level per line
    input  wire logic [1:0] r_bit, // right mic level per line
    output logic      [1:0] line   // shared data lines
);
    // left mic drives after the falling edge, right mic after the rising edge
    initial line = 2'b00;
    always @(negedge bclk) line <= #2 l_bit;
    always @(posedge bclk) line <= #2 r_bit;
endmodule

// *** verif/tb_mpp_top.sv ***
// self-checking bench for the multipurpose pin block
`timescale 1ns/1ps
`include "mpp_consts.svh"
module tb_mpp_top;
    import mpp_pkg::*;
    localparam int          FB = 8;
    localparam logic [15:0] MB = `MPP_IDX_MODE_BASE;
    localparam logic [1:0]  OK = `MPP_RESP_OKAY;
    localparam logic [1:0]  SE = `MPP_RESP_SLVERR;
    logic             aclk, aresetn, port_bit_clk, panic_flag, spi_ss_n;
    logic             awvalid, wvalid, bready, arvalid, rready;
    logic [17:0]      awaddr, araddr;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic [13:0]      ext, gpo;
    logic [1:0]       l_bit, r_bit;
    wire logic        awready, wready, bvalid, arready, rvalid, bcm, msv;
    wire logic [1:0]  bresp, rresp, mline;
    wire logic [31:0] rdata;
    wire logic [13:0] pi, po, poe, ppu, gpi, gpv;
    wire logic [3:0][6:0] ms;
    int               error_cnt, tests_run, cyc;
    // pin wire level: device drive wins, else the outside world
    assign pi = (po & poe) | (~poe & {ext[13:4], mline, ext[1:0]});
    mpp_mic_model mic (.bclk(port_bit_clk), .l_bit, .r_bit, .line(mline));
    mpp_top #(.FRAME_BITS(FB), .DEB_CYCLES(2)) uut (.aclk, .aresetn, .port_bit_clk,
        .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .multipurpose_pin_i(pi), .multipurpose_pin_o(po), .multipurpose_pin_oe(poe),
        .multipurpose_pin_pu(ppu), .dsp_gp_out(gpo), .dsp_gp_in(gpi),
        .dsp_gp_in_valid(gpv), .panic_flag, .spi_ss_n, .bit_clk_master_oe(bcm),
        .mic_sample(ms), .mic_sample_valid(msv));
    // system clock and unrelated link clock
    initial
    begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    initial
    begin
        port_bit_clk = 1'b0;
        #1.3;
        forever #6 port_bit_clk = ~port_bit_clk;
    end
    // hang guard
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            conclude();
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        begin
            tests_run++;
            if (seen !== exp)
            begin
                error_cnt++;
                $display("Error at %0t: got %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wr(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er);
        logic ah;
        logic wh;
        begin
            @(posedge aclk); // a strobe lowered by the last call stays low one edge
            awaddr <= {idx, 2'b00};
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            ah = 1'b0;
            wh = 1'b0;
            while (!(ah && wh))
            begin
                @(posedge aclk);
                if (!ah && awready)
                begin
                    ah = 1'b1;
                    awvalid <= 1'b0;
                end
                if (!wh && wready)
                begin
                    wh = 1'b1;
                    wvalid <= 1'b0;
                end
            end
            do @(posedge aclk); while (!bvalid);
            bready <= 1'b0;
            chk({30'h0, bresp}, {30'h0, er});
        end
    endtask
    task rd(input logic [15:0] idx, input logic [31:0] e, input logic [1:0] er);
        begin
            @(posedge aclk); // a strobe lowered by the last call stays low one edge
            araddr <= {idx, 2'b00};
            arvalid <= 1'b1;
            rready <= 1'b1;
            do @(posedge aclk); while (!arready);
            arvalid <= 1'b0;
            do @(posedge aclk); while (!rvalid);
            rready <= 1'b0;
            chk(rdata, e);
            chk({30'h0, rresp}, {30'h0, er});
        end
    endtask
    // wait for n sample ticks, then let the pin state settle
    task frames(input int n);
        begin
            repeat (n) do @(posedge aclk); while (!msv);
            repeat (3) @(posedge aclk);
        end
    endtask
    task conclude;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
            if (error_cnt == 0 && tests_run > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    // main sequence
    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready, panic_flag} = 6'h00;
        aresetn <= 1'b0; // late in the step so every reset flop sees the fall
        {awaddr, araddr, wdata, ext, gpo, l_bit, r_bit} = '0;
        {wstrb, spi_ss_n, error_cnt, tests_run, cyc} = {4'hF, 1'b1, 96'h0};
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(MB, 32'h0, OK);
        rd(`MPP_IDX_MIC0, 32'h0, OK);
        rd(`MPP_IDX_MIC1, 32'h0, OK);
        rd(`MPP_IDX_SWIN, 32'h0, OK);
        chk({18'h0, poe}, 32'h0);
        wr(MB + 16'hD, 32'hFFFFFFFF, OK);
        rd(MB + 16'hD, 32'h0000000F, OK);
        wr(MB + 16'hD, 32'h0, OK);
        wr(`MPP_IDX_MIC1, 32'hFFFFFFFF, OK);
        rd(`MPP_IDX_MIC1, 32'h0000FFFF, OK);
        wstrb <= 4'h2;
        wr(`MPP_IDX_MIC1, 32'h0, OK);
        rd(`MPP_IDX_MIC1, 32'h000000FF, OK);
        wstrb <= 4'hF;
        wr(`MPP_IDX_MIC1, 32'h0, OK);
        wr(16'h1234, 32'h5, SE);
        rd(16'h1234, 32'h0, SE);
        $display("registers done");
        ext <= 14'h00A0;
        wr(MB + 16'h4, 32'h1, OK);
        wr(MB + 16'h7, 32'h1, OK);
        wr(MB, 32'h1, OK);
        wr(`MPP_IDX_SWIN, 32'h11, OK);
        frames(2);
        chk({18'h0, gpi}, 32'h31);
        chk({18'h0, gpv}, 32'h3FFF);
        rd(`MPP_IDX_GPIN, 32'h31, OK);
        $display("inputs done");
        wr(MB + 16'h6, 32'h8, OK);
        repeat (60)
        begin
            @(posedge aclk);
            ext[6] <= (cyc % 3 == 0);
            chk({31'h0, gpi[6]}, 32'h0);
        end
        @(posedge aclk);
        ext[6] <= 1'b1;
        frames(2);
        chk({31'h0, gpi[6]}, 32'h1);
        $display("debounce done");
        gpo <= 14'h1300;
        panic_flag <= 1'b1;
        spi_ss_n <= 1'b0;
        wr(MB + 16'h8, 32'h2, OK);
        wr(MB + 16'h9, 32'h3, OK);
        wr(MB + 16'hA, 32'h5, OK);
        wr(MB + 16'hB, 32'h6, OK);
        frames(2);
        chk({18'h0, po & 14'h0F00}, 32'h0700);
        chk({18'h0, poe}, 32'h0F00);
        chk({18'h0, ppu}, 32'h0100);
        gpo <= 14'h0100;
        repeat (4) @(posedge aclk);
        chk({31'h0, po[9]}, 32'h1);
        frames(1);
        chk({31'h0, po[9]}, 32'h0);
        $display("outputs done");
        l_bit <= 2'b11;
        r_bit <= 2'b10;
        wr(MB + 16'h2, 32'h4, OK);
        wr(MB + 16'h3, 32'h4, OK);
        wr(`MPP_IDX_MIC0, 32'h12, OK);
        wr(`MPP_IDX_MIC1, 32'h13, OK);
        wr(`MPP_IDX_LINK, 32'h1, OK);
        chk({31'h0, bcm}, 32'h1);
        frames(3);
        chk({4'h0, ms}, {4'h0, 7'(FB), 7'(FB), 7'd0, 7'(FB)});
        chk({30'h0, gpv[3:2]}, 32'h0);
        wr(`MPP_IDX_MIC0, 32'h13, OK);
        frames(3);
        chk({4'h0, ms}, {4'h0, 7'(FB), 7'(FB), 7'(FB), 7'(FB)});
        $display("microphones done");
        conclude();
    end
endmodule
